// ===== logic/asof_pipe.sv
/*
 Fixed-length delay line for the coded output words.
 Assumes one clock; every stage advances on every rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asof_regs.svh"

module asof_pipe #(
   parameter int DEPTH = `ASOF_LATENCY,
   parameter int WIDTH = `ASOF_CODE_W
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] stage_q [DEPTH];
   logic [WIDTH-1:0] stage_d [DEPTH];

   // ----------------------------------------
   // Shift stages
   // ----------------------------------------
   // No reset: the converter itself has none, and stale words flush out.
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++) begin : gen_stage
         if (g == 0) begin : gen_first
            always_comb stage_d[g] = din;
         end else begin : gen_rest
            always_comb stage_d[g] = stage_q[g-1];
         end
         always_ff @(posedge clk) begin
            stage_q[g] <= stage_d[g];
         end
      end
   endgenerate

   assign dout = stage_q[DEPTH-1];
endmodule
`default_nettype wire

// ===== logic/asof_pkg.sv
/*
 Types of the sample output formatter.
 Assumes nothing beyond the constants header.
*/
`default_nettype none
`include "asof_regs.svh"

package asof_pkg;
   typedef logic [`ASOF_CODE_W-1:0] asof_code_type;
   typedef enum logic [0:0] {
      ASOF_FMT_TWOS   = 1'b0,
      ASOF_FMT_OFFSET = 1'b1
   } asof_fmt_type;
endpackage
`default_nettype wire

// ===== logic/asof_regs.svh
/*
 Constants of the sample output formatter: code widths, codes, latency and rate.
 Assumes inclusion by bare name from design files only.
*/
`ifndef ASOF_REGS_SVH
`define ASOF_REGS_SVH

`define ASOF_CODE_W        12
`define ASOF_LATENCY       10
`define ASOF_OB_MIN        12'h000
`define ASOF_OB_MID        12'h800
`define ASOF_OB_MAX        12'hfff
`define ASOF_TC_MAX        12'h7ff
`define ASOF_TC_MIN        12'h800
`define ASOF_MSB_POS       11
`define ASOF_MIN_RATE_MSPS 10
`define ASOF_CLK_MHZ       20
`define ASOF_DITHER_SEED   16'hace1

`endif

// ===== logic/asof_top.sv
/*
 Output formatter of a 12-bit pipelined sampling converter: strap capture,
 threshold dither, coding and fixed latency to latched output pins.
 Assumes clk is the true sample clock and sample_code is produced on clk.
*/
`timescale 1ns/10ps
`default_nettype none
`include "asof_regs.svh"

module asof_top #(
   parameter int LATENCY = `ASOF_LATENCY
) (
   input  wire logic                      clk,
   input  wire logic                      sys_rst,
   input  wire logic [`ASOF_CODE_W-1:0]   sample_code,
   input  wire logic                      output_format_select,
   input  wire logic                      output_format_select_oe,
   input  wire logic                      spur_reduction_select,
   output logic      [`ASOF_CODE_W-1:0]   data_out
);
   // ----------------------------------------
   // Strap synchronisers
   // ----------------------------------------
   logic fmt_s1_q, fmt_s2_q;
   logic fmt_oe_s1_q, fmt_oe_s2_q;
   logic spur_s1_q, spur_s2_q;
   logic fmt_sel;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         fmt_s1_q    <= 1'b0;
         fmt_s2_q    <= 1'b0;
         fmt_oe_s1_q <= 1'b0;
         fmt_oe_s2_q <= 1'b0;
         spur_s1_q   <= 1'b0;
         spur_s2_q   <= 1'b0;
      end else begin
         fmt_s1_q    <= output_format_select;
         fmt_s2_q    <= fmt_s1_q;
         fmt_oe_s1_q <= output_format_select_oe;
         fmt_oe_s2_q <= fmt_oe_s1_q;
         spur_s1_q   <= spur_reduction_select;
         spur_s2_q   <= spur_s1_q;
      end
   end

   // A floating format pin is weakly pulled low. Pin and drive sense are
   // combined only after both are synchronised, so skew between them
   // cannot glitch the first stage.
   always_comb fmt_sel = fmt_s2_q & fmt_oe_s2_q;

   // ----------------------------------------
   // Threshold dither
   // ----------------------------------------
   // A small LFSR nudges the decision point by at most one code. It only
   // moves thresholds, so average linearity is kept while spurs spread.
   logic [15:0] lfsr_q, lfsr_d;
   logic        spur_on;
   asof_pkg::asof_code_type sampled;

   always_comb begin
      spur_on = spur_s2_q;
      lfsr_d  = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      sampled = sample_code;
      if (spur_on && lfsr_q[0] && sample_code != `ASOF_OB_MAX) begin
         sampled = sample_code + 12'h001;
      end
      // Spur select low leaves the transfer static.
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lfsr_q <= `ASOF_DITHER_SEED;
      end else begin
         lfsr_q <= lfsr_d;
      end
   end

   // ----------------------------------------
   // Coding
   // ----------------------------------------
   // Format is applied at sampling, so each word carries its own coding
   // through the pipe and a strap change never alters words in flight.
   asof_pkg::asof_code_type coded;
   asof_pkg::asof_fmt_type  fmt;

   always_comb begin
      fmt   = asof_pkg::asof_fmt_type'(fmt_sel);
      coded = sampled;
      if (fmt == asof_pkg::ASOF_FMT_TWOS) begin
         coded = sampled ^ `ASOF_TC_MIN;
      end
      // Offset binary passes through unchanged.
   end

   // ----------------------------------------
   // Latency and output latch
   // ----------------------------------------
   asof_pkg::asof_code_type piped;
   asof_pkg::asof_code_type out_d;

   // Sampling on clk rising edge; the pipe plus output flop give LATENCY.
   asof_pipe #(
      .DEPTH (LATENCY - 1),
      .WIDTH (`ASOF_CODE_W)
   ) u_pipe (
      .clk  (clk),
      .din  (coded),
      .dout (piped)
   );

   always_comb out_d = piped;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         data_out <= `ASOF_OB_MIN;
      end else begin
         data_out <= out_d;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Raw input, strap state and dither decision, each delayed LATENCY
   // cycles so that they line up with the word on data_out.
   logic [`ASOF_CODE_W-1:0] ref_q [LATENCY];
   logic [LATENCY-1:0]      fmt_h_q;
   logic [LATENCY-1:0]      spur_h_q;
   logic [3:0]              up_q;

   always_ff @(posedge clk) begin
      ref_q[0]    <= sample_code;
      fmt_h_q[0]  <= fmt_sel;
      spur_h_q[0] <= spur_s2_q & lfsr_q[0];
      for (int i = 1; i < LATENCY; i++) begin
         ref_q[i]    <= ref_q[i-1];
         fmt_h_q[i]  <= fmt_h_q[i-1];
         spur_h_q[i] <= spur_h_q[i-1];
      end
      up_q <= (up_q < 4'hf) ? up_q + 4'h1 : up_q;
      if (sys_rst) begin
         up_q <= 4'h0;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   chk_offset_binary: assert property (@(posedge clk) disable iff (sys_rst)
      (up_q > 4'hb && fmt_h_q[LATENCY-1] && !spur_h_q[LATENCY-1] && ref_q[LATENCY-1] != 12'hfff)
      |-> data_out == ref_q[LATENCY-1]) else $error("offset binary word wrong");

   chk_offset_pass: assert property (@(posedge clk) disable iff (sys_rst)
      fmt_sel |-> coded == sampled) else $error("offset binary coding altered");

   chk_full_scale: assert property (@(posedge clk) disable iff (sys_rst)
      sample_code == `ASOF_OB_MAX |-> sampled == `ASOF_OB_MAX)
      else $error("dither passed full scale");

   chk_twos_compl: assert property (@(posedge clk) disable iff (sys_rst)
      (up_q > 4'hb && !fmt_h_q[LATENCY-1] && !spur_h_q[LATENCY-1])
      |-> data_out == (ref_q[LATENCY-1] ^ 12'h800)) else $error("twos complement word wrong");

   chk_twos_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (!fmt_sel && !spur_s2_q && sample_code == `ASOF_OB_MID) |-> coded == 12'h000)
      else $error("twos complement zero wrong");

   chk_latency_ten: assert property (@(posedge clk) disable iff (sys_rst)
      (!spur_s2_q && fmt_sel && sample_code == 12'h800)
      |-> ##10 data_out == 12'h800) else $error("latency is not ten cycles");

   chk_out_registered: assert property (@(posedge clk) disable iff (sys_rst)
      up_q > 4'hb |-> data_out == $past(out_d)) else $error("output not a registered word");

   chk_static_mode: assert property (@(posedge clk) disable iff (sys_rst)
      !spur_s2_q |-> sampled == sample_code) else $error("dither active while disabled");

   chk_dither_bound: assert property (@(posedge clk) disable iff (sys_rst)
      spur_s2_q |-> (sampled - sample_code) <= 12'h001) else $error("dither exceeds one code");

   // An all-zero dither register would lock up and silently stop the dither.
   chk_lfsr_alive: assert property (@(posedge clk) disable iff (sys_rst)
      lfsr_q != 16'h0000) else $error("dither register locked at zero");

   chk_float_low: assert property (@(posedge clk) disable iff (sys_rst)
      (!output_format_select_oe)[*3] |=> !fmt_sel) else $error("floating format not low");

   chk_spur_high: assert property (@(posedge clk) disable iff (sys_rst)
      spur_reduction_select ##2 1'b1 |-> spur_on) else $error("spur select high ignored");

   chk_spur_low: assert property (@(posedge clk) disable iff (sys_rst)
      (!spur_reduction_select)[*3] |=> !spur_on) else $error("spur select low ignored");

   // A format change must leave the word sampled just before it in its old coding.
   chk_strap_inflight: assert property (@(posedge clk) disable iff (sys_rst)
      (up_q > 4'hb && $changed(fmt_sel) && !$past(spur_s2_q))
      |-> ##9 data_out == (fmt_h_q[LATENCY-1] ? ref_q[LATENCY-1] : ref_q[LATENCY-1] ^ 12'h800))
      else $error("format change reached a word in flight");

   chk_reset_word: assert property (@(posedge clk)
      sys_rst |=> data_out == `ASOF_OB_MIN) else $error("output not cleared by reset");

   // ----------------------------------------
   // Coverage
   // ----------------------------------------
   cov_offset: cover property (@(posedge clk) fmt_h_q[LATENCY-1] && data_out == 12'hfff);
   cov_twos: cover property (@(posedge clk) !fmt_h_q[LATENCY-1] && data_out == 12'h800);
   cov_dither: cover property (@(posedge clk) spur_on && sampled != sample_code);
   cov_float: cover property (@(posedge clk) !fmt_oe_s2_q && fmt_s2_q);
   cov_strap_change: cover property (@(posedge clk) $changed(fmt_sel));
endmodule
`default_nettype wire

// ===== verification/asof_capture.sv
/*
 Capture logic at the far side of the formatter: registers each word.
 Assumes it shares the sample clock with the formatter.
*/
`timescale 1ns/10ps
`default_nettype none

module asof_capture (
   input  wire logic                   clk,
   input  wire asof_pkg::asof_code_type word_in,
   output asof_pkg::asof_code_type      word_q
);
   // Sampling on the rising edge only is why the word must hold all cycle.
   always_ff @(posedge clk) begin
      word_q <= word_in;
   end
endmodule

`default_nettype wire

// ===== verification/test_adc_sample_output_formatter.sv
/*
 Self-checking bench of the output formatter with a capture partner.
 Assumes the formatter and capture model are compiled before it.
*/
`timescale 1ns/10ps
`default_nettype none

module test_adc_sample_output_formatter;
   logic                    clk;
   logic                    sys_rst;
   asof_pkg::asof_code_type sample_code;
   logic                    fmt, fmt_oe, spur;
   asof_pkg::asof_code_type data_out, cap_q, prev_seen, exp_w, dith_w;
   asof_pkg::asof_code_type h_code [16];
   logic [15:0]             h_fmt, h_spur, h_ok;
   logic [1:0]              prev_mode;
   logic [31:0]             lfsr = 32'h2aa756c4;
   int fail_count = 0, checks_done = 0, n = 0, rel = 100000, last_chg = -100, dithers = 0, k;

   asof_top dut (.clk(clk), .sys_rst(sys_rst), .sample_code(sample_code),
      .output_format_select(fmt), .output_format_select_oe(fmt_oe),
      .spur_reduction_select(spur), .data_out(data_out));
   asof_capture partner (.clk(clk), .word_in(data_out), .word_q(cap_q));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // Dither lifts one code in offset order, saturating; coding follows.
   function automatic asof_pkg::asof_code_type coded(input asof_pkg::asof_code_type c,
      input logic f, input logic up);
      if (up && c != 12'hfff) c = c + 12'h001;
      return f ? c : c ^ 12'h800;
   endfunction
   task automatic check(input asof_pkg::asof_code_type seen, input asof_pkg::asof_code_type exp,
      input string what);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic phase(input logic f, input logic oe, input logic s, input int len);
      asof_pkg::asof_code_type corner [4];
      corner = '{12'h000, 12'h800, 12'hfff, 12'h7ff};
      for (int i = 0; i < len; i++) begin
         @(posedge clk);
         #1;
         fmt = f;
         fmt_oe = oe;
         spur = s;
         lfsr = lfsr_next(lfsr);
         sample_code = (i > 4 && i < 9) ? corner[i-5] : lfsr[11:0];
      end
   endtask

   // ----------------------------------------
   // Clock, stimulus and checking
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      k = n % 16;
      h_code[k] = sample_code;
      h_fmt[k] = fmt & fmt_oe;
      h_spur[k] = spur;
      if ({fmt & fmt_oe, spur} != prev_mode) last_chg = n;
      prev_mode = {fmt & fmt_oe, spur};
      h_ok[k] = (n - last_chg) >= 4;
      #2;
      k = (n + 7) % 16;
      if (n >= rel + 11) check(cap_q, prev_seen, "held word");
      if (n >= rel + 10 && h_ok[k]) begin
         exp_w = coded(h_code[k], h_fmt[k], 1'b0);
         dith_w = coded(h_code[k], h_fmt[k], 1'b1);
         if (h_spur[k] && data_out === dith_w && dith_w !== exp_w) begin
            exp_w = dith_w;
            dithers++;
         end
         check(data_out, exp_w, "word");
      end
      prev_seen = data_out;
      n++;
      if (n > 2000) begin
         fail_count++;
         complete_run();
      end
   end
   initial begin
      sys_rst = 1'b1;
      sample_code = 12'h000;
      fmt = 1'b0;
      fmt_oe = 1'b1;
      spur = 1'b0;
      prev_mode = 2'b00;
      repeat (8) @(posedge clk);
      #1;
      check(data_out, 12'h000, "reset word");
      sys_rst = 1'b0;
      rel = n;
      phase(1'b1, 1'b1, 1'b0, 40);
      phase(1'b0, 1'b1, 1'b0, 40);
      phase(1'b1, 1'b0, 1'b0, 40);
      phase(1'b1, 1'b1, 1'b1, 80);
      check({11'h000, dithers > 0}, 12'h001, "dither seen");
      phase(1'b0, 1'b1, 1'b0, 30);
      repeat (12) @(posedge clk);
      #10;
      complete_run();
   end
endmodule

`default_nettype wire
